// File: inc/doss_consts.svh
// offsets, field positions, reset values and trims for the output sum and sync block
`ifndef DOSS_CONSTS_SVH
`define DOSS_CONSTS_SVH
`define DOSS_AW          12
`define DOSS_A_CTRL      12'h000
`define DOSS_A_SUMSEL    12'h004
`define DOSS_A_SYNCSEL   12'h008
`define DOSS_A_CONST     12'h00c
`define DOSS_A_STATUS    12'h010
`define DOSS_A_FREQ      12'h020
`define DOSS_F_TWOS      0
`define DOSS_F_WMODE     1
`define DOSS_F_CONST_EN  3
`define DOSS_F_NCO_EN    4
`define DOSS_F_TRIM      8
`define DOSS_F_SYNC      12
`define DOSS_F_MIXSEL    4
`define DOSS_R_CTRL      32'h0000_0a00
`define DOSS_R_SUMSEL    8'h33
`define DOSS_R_SYNCSEL   8'hff
`define DOSS_TRIM_BIAS   11
`define DOSS_SRC_AUTO    0
`define DOSS_SRC_REG     1
`define DOSS_SRC_SYSREF  2
`define DOSS_SRC_ILA     3
`define DOSS_RESP_OK     2'b00
`define DOSS_RESP_SLV    2'b10
`endif

// File: inc/doss_pkg.sv
// types shared by the output sum and sync block
package doss_pkg;
    typedef struct packed {
        logic [15:0] i;
        logic [15:0] q;
    } doss_iq_t;
    typedef enum logic [1:0] {
        DOSS_W16 = 2'b00,
        DOSS_W14 = 2'b01,
        DOSS_W12 = 2'b10
    } doss_width_t;
endpackage

// File: verilog/doss_top.sv
// upconverter paths, output summation and sync sources behind an axi4-lite slave
// Functional notes
// - samples are offset binary or two's complement, chosen by a control bit
// - samples are 16-bit msb aligned; 14-bit mode drops 4 lsbs, 12-bit drops 2
// - format conversion only inverts the msb, all other bits kept
// - two's complement full scale 7fff/8000; offset binary zero is 8000
// - coarse trim output is twice the difference of the 4-bit trim field and 11
// - each path output passes an inverse sinc filter before summation
// - each channel sum adds up to four selectable paths, own and neighbor
// - sum inputs are 16 bits, result rounded back to 16 bits without overflow
// - with n paths added, output takes bits [15+n:n], low n bits round
// - a completed write to a frequency high word makes an auto sync pulse
// - writing the register sync bit as one makes a register sync pulse
// - sysref captured on the core clock is a selectable sync source
// - lane alignment completion gives exactly one selectable sync pulse
// - all four paths carry identical sync logic
// - oscillator accumulates 48-bit word, adds 16-bit phase to upper 16 bits
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "doss_consts.svh"
module doss_top #(
    parameter int NPATH = 4
) (
    input  wire logic                        core_clk,      // 40 mhz sample clock
    input  wire logic                        sys_rst,       // sync reset, active high
    input  wire logic                        ce,            // clock enable, freezes all
    input  wire doss_pkg::doss_iq_t [NPATH-1:0] link_iq,   // samples from link receiver
    input  wire logic                        ila_done,      // lane alignment done level
    input  wire logic                        sysref_pin,    // asynchronous sysref
    input  wire logic [11:0]                 s_axi_awaddr,  // write address
    input  wire logic                        s_axi_awvalid, // write address valid
    output logic                             s_axi_awready, // write address ready
    input  wire logic [31:0]                 s_axi_wdata,   // write data
    input  wire logic [3:0]                  s_axi_wstrb,   // byte enables
    input  wire logic                        s_axi_wvalid,  // write data valid
    output logic                             s_axi_wready,  // write data ready
    output logic [1:0]                       s_axi_bresp,   // write response
    output logic                             s_axi_bvalid,  // write response valid
    input  wire logic                        s_axi_bready,  // write response ready
    input  wire logic [11:0]                 s_axi_araddr,  // read address
    input  wire logic                        s_axi_arvalid, // read address valid
    output logic                             s_axi_arready, // read address ready
    output logic [31:0]                      s_axi_rdata,   // read data
    output logic [1:0]                       s_axi_rresp,   // read response
    output logic                             s_axi_rvalid,  // read data valid
    input  wire logic                        s_axi_rready,  // read data ready
    output logic [1:0][15:0]                 ch_out,        // two channel sums
    output logic signed [5:0]                coarse_trim    // coarse trim current, ma
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // saturate a wide signed value into 16 bits
    function automatic logic [15:0] sat16(input logic signed [21:0] v);
        if (v > 22'sd32767) return 16'h7fff;
        if (v < -22'sd32768) return 16'h8000;
        return v[15:0];
    endfunction

    // negate with the most negative code clamped
    function automatic logic [15:0] neg16(input logic [15:0] v);
        return (v == 16'h8000) ? 16'h7fff : 16'(-v);
    endfunction

    // merge a write word into a register under byte enables
    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) r[8*b +: 8] = n[8*b +: 8];
        end
        return r;
    endfunction

    // frequency window decode, used by read and write
    function automatic logic freq_hit(input logic [11:0] a);
        return (a >= `DOSS_A_FREQ) && (a < 12'(`DOSS_A_FREQ + 8 * NPATH));
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // registers and bus state

    logic [31:0]               ctrl;
    logic [7:0]                sum_sel;
    logic [7:0]                sync_sel;
    logic [15:0]               const_val;
    logic [2*NPATH-1:0][31:0]  freq_reg;     // even: word low, odd: word high and phase
    logic                      aw_held;
    logic                      w_held;
    logic [11:0]               wa;
    logic [31:0]               wd;
    logic [3:0]                ws;
    logic                      reg_pulse;
    logic                      auto_pulse;
    logic                      sr1;
    logic                      sr2;
    logic                      sr3;
    logic                      ila_d;
    logic [NPATH-1:0][15:0]    fir_out;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // write channel decode
    wire        aw_take   = s_axi_awvalid & s_axi_awready;
    wire        w_take    = s_axi_wvalid & s_axi_wready;
    wire        do_wr     = aw_held & w_held & ~s_axi_bvalid;
    wire        next_awh  = (aw_held | aw_take) & ~do_wr;
    wire        next_wh   = (w_held | w_take) & ~do_wr;
    wire [11:0] wa_word   = {wa[11:2], 2'b00};
    wire        wr_fhit   = freq_hit(wa_word);
    wire [2:0]  wr_idx    = 3'(wa_word[5:2]);
    wire        wr_map    = wr_fhit || wa_word <= `DOSS_A_STATUS;
    wire        wr_ctrl   = do_wr && wa_word == `DOSS_A_CTRL;
    wire [31:0] ctrl_new  = wmerge(ctrl, wd, ws);

    // read channel decode; unmapped reads answer zero with a slave error
    wire        ar_take   = s_axi_arvalid & s_axi_arready;
    wire [11:0] ra        = {s_axi_araddr[11:2], 2'b00};
    wire        rd_fhit   = freq_hit(ra);
    wire [2:0]  rd_idx    = 3'(ra[5:2]);
    wire [2:0]  sel_cnt;
    wire [31:0] status    = {2'b00, coarse_trim, 5'h00, sel_cnt, ch_out[0]};
    wire        rd_map    = rd_fhit || ra <= `DOSS_A_STATUS;
    wire [31:0] rd_mux    = rd_fhit ? freq_reg[rd_idx] :
                            ra == `DOSS_A_CTRL    ? ctrl :
                            ra == `DOSS_A_SUMSEL  ? {24'h0, sum_sel} :
                            ra == `DOSS_A_SYNCSEL ? {24'h0, sync_sel} :
                            ra == `DOSS_A_CONST   ? {16'h0, const_val} :
                            ra == `DOSS_A_STATUS  ? status : 32'h0;

    // axi write handshake; address and data taken in either order
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DOSS_RESP_OK;
        end else if (ce) begin
            aw_held       <= next_awh;
            w_held        <= next_wh;
            s_axi_awready <= ~next_awh;
            s_axi_wready  <= ~next_wh;
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? `DOSS_RESP_OK : `DOSS_RESP_SLV;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // capture address and data words as they are taken
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wa <= 12'h000;
            wd <= 32'h0;
            ws <= 4'h0;
        end else if (ce) begin
            if (aw_take) wa <= s_axi_awaddr;
            if (w_take) wd <= s_axi_wdata;
            if (w_take) ws <= s_axi_wstrb;
        end
    end

    // axi read handshake; one read outstanding, arready drops until rdata is taken
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `DOSS_RESP_OK;
        end else if (ce) begin
            s_axi_arready <= ~(ar_take | (s_axi_rvalid & ~s_axi_rready));
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_map ? `DOSS_RESP_OK : `DOSS_RESP_SLV;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // control registers; the sync bit never stores, it only fires a pulse
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl      <= `DOSS_R_CTRL;
            sum_sel   <= `DOSS_R_SUMSEL;
            sync_sel  <= `DOSS_R_SYNCSEL;
            const_val <= 16'h0000;
            freq_reg  <= '0;
        end else if (ce && do_wr) begin
            if (wa_word == `DOSS_A_CTRL) ctrl <= ctrl_new & ~(32'h1 << `DOSS_F_SYNC);
            if (wa_word == `DOSS_A_SUMSEL) sum_sel <= 8'(wmerge(32'(sum_sel), wd,
                ws));
            if (wa_word == `DOSS_A_SYNCSEL) sync_sel <= 8'(wmerge(32'(sync_sel), wd,
                ws));
            if (wa_word == `DOSS_A_CONST) const_val <= 16'(wmerge(32'(const_val), wd,
                ws));
            if (wr_fhit) freq_reg[wr_idx] <= wmerge(freq_reg[wr_idx], wd, ws);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sync sources

    // sysref is asynchronous: sr1 feeds only sr2, edge found on sr2/sr3
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sr1        <= 1'b0;
            sr2        <= 1'b0;
            sr3        <= 1'b0;
            ila_d      <= 1'b0;
            reg_pulse  <= 1'b0;
            auto_pulse <= 1'b0;
        end else if (ce) begin
            sr1        <= sysref_pin;
            sr2        <= sr1;
            sr3        <= sr2;
            ila_d      <= ila_done;
            reg_pulse  <= wr_ctrl && ctrl_new[`DOSS_F_SYNC];
            auto_pulse <= do_wr && wr_fhit && wa_word[2];
        end
    end

    // one pulse per rising lane-alignment level, however long it stays high
    wire       ev_ila   = ila_done & ~ila_d;
    wire       ev_sys   = sr2 & ~sr3;
    wire [3:0] ev       = {ev_ila, ev_sys, reg_pulse, auto_pulse};
    wire       osc_sync = |(ev & sync_sel[3:0]);
    wire       mix_sync = |(ev & sync_sel[`DOSS_F_MIXSEL +: 4]);

    ////////////////////////////////////////////////////////////////////////////////
    // upconverter paths, identical per path

    wire                 twos   = ctrl[`DOSS_F_TWOS];
    wire                 nco_en = ctrl[`DOSS_F_NCO_EN];
    wire [1:0]           wm_raw = ctrl[`DOSS_F_WMODE +: 2];
    doss_pkg::doss_width_t wm;
    assign wm = doss_pkg::doss_width_t'(wm_raw);
    wire [15:0]          wmask  = (wm == doss_pkg::DOSS_W14) ? 16'hfff0 :
                                  (wm == doss_pkg::DOSS_W12) ? 16'hfffc : 16'hffff;

    genvar p;
    generate
        for (p = 0; p < NPATH; p++) begin : g_path
            logic [47:0] acc;
            logic [1:0]  mseq;
            logic [15:0] mx;
            logic [15:0] d1;
            logic [15:0] d2;
            wire doss_pkg::doss_iq_t src = ctrl[`DOSS_F_CONST_EN] ? {const_val, const_val}
                                                                   : link_iq[p];
            // offset binary becomes two's complement by flipping the msb alone
            wire [15:0] ti = twos ? src.i : {~src.i[15], src.i[14:0]};
            wire [15:0] tq = twos ? src.q : {~src.q[15], src.q[14:0]};
            wire [15:0] mi = ti & wmask;
            wire [15:0] mq = tq & wmask;
            wire [15:0] ph = acc[47:32] + freq_reg[2*p+1][31:16];
            wire [1:0]  qd = nco_en ? ph[15:14] : mseq;
            // cos and sin only take 1, 0 or -1 at the quadrant points
            wire [15:0] mix_v = (qd == 2'd0) ? mi : (qd == 2'd1) ? neg16(mq) :
                                (qd == 2'd2) ? neg16(mi) : mq;
            wire signed [21:0] fir_acc = 22'sd18 * $signed(d1) - $signed(mx)
                                         - $signed(d2) + 22'sd8;
            // accumulator restarts on osc_sync, mixer sequence on mix_sync, each by its own select
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    acc  <= 48'h0;
                    mseq <= 2'b00;
                end else if (ce) begin
                    acc  <= osc_sync ? 48'h0 :
                            acc + {freq_reg[2*p+1][15:0], freq_reg[2*p]};
                    mseq <= mix_sync ? 2'b00 : 2'(mseq + 2'd1);
                end
            end
            // three-tap droop compensation, unity gain at dc
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    mx         <= 16'h0;
                    d1         <= 16'h0;
                    d2         <= 16'h0;
                    fir_out[p] <= 16'h0;
                end else if (ce) begin
                    mx         <= mix_v;
                    d1         <= mx;
                    d2         <= d1;
                    fir_out[p] <= sat16(fir_acc >>> 4);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // channel summation; channel c owns paths 2c and 2c+1

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_sum
            // select order: own first, own second, neighbor first, neighbor second
            wire [3:0] sel = sum_sel[4*c +: 4];
            wire signed [21:0] a0 = sel[0] ? 22'($signed(fir_out[2*c]))     : 22'sd0;
            wire signed [21:0] a1 = sel[1] ? 22'($signed(fir_out[2*c+1]))   : 22'sd0;
            wire signed [21:0] a2 = sel[2] ? 22'($signed(fir_out[2-2*c]))   : 22'sd0;
            wire signed [21:0] a3 = sel[3] ? 22'($signed(fir_out[3-2*c]))   : 22'sd0;
            wire [2:0]  n = 3'(sel[0]) + 3'(sel[1]) + 3'(sel[2]) + 3'(sel[3]);
            wire signed [21:0] sum  = a0 + a1 + a2 + a3;
            wire signed [21:0] half = (n == 3'd0) ? 22'sd0 : 22'sd1 <<< (n - 3'd1);
            wire signed [21:0] rnd  = (sum + half) >>> n;
            always_ff @(posedge core_clk) begin
                if (sys_rst) ch_out[c] <= 16'h0;
                else if (ce) ch_out[c] <= sat16(rnd);
            end
        end
    endgenerate
    assign sel_cnt = g_sum[0].n;

    // full-scale trim: 2 * (field - 11) ma on top of the bias current
    always_ff @(posedge core_clk) begin
        if (sys_rst) coarse_trim <= 6'sd0;
        else if (ce) coarse_trim <= 6'(2 * ({2'b00, ctrl[`DOSS_F_TRIM +: 4]} - 6'd11));
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    sequence ctrl_sync_wr_s;
        do_wr && ce && wa_word == `DOSS_A_CTRL && ws[1] && wd[`DOSS_F_SYNC]
            && sync_sel[`DOSS_F_MIXSEL + `DOSS_SRC_REG];
    endsequence
    sequence freq_hi_wr_s;
        do_wr && ce && wr_fhit && wa_word[2] && sync_sel[`DOSS_F_MIXSEL];
    endsequence
    sequence sysref_rise_s;
        $rose(sysref_pin) && ce && sync_sel[`DOSS_SRC_SYSREF] ##1 ce [*2];
    endsequence

    reg_sync_a: assert property (ctrl_sync_wr_s ##1 ce |=> g_path[0].mseq == 2'b00)
        else $error("register sync did not restart mixer");
    auto_sync_a: assert property (freq_hi_wr_s ##1 ce |=> g_path[1].mseq == 2'b00)
        else $error("auto sync did not restart mixer");
    sysref_sync_a: assert property (sysref_rise_s |=> g_path[2].acc == 48'h0)
        else $error("sysref sync did not clear accumulator");
    ila_once_a: assert property (ev_ila && ce |=> !ev_ila)
        else $error("lane alignment pulse longer than one cycle");
    nco_step_a: assert property (ce && !osc_sync |=> g_path[3].acc ==
        $past(g_path[3].acc) + {$past(freq_reg[7][15:0]), $past(freq_reg[6])})
        else $error("oscillator accumulator step wrong");
    ob_zero_a: assert property (!twos && ctrl[`DOSS_F_CONST_EN] && const_val == 16'h8000
        |-> g_path[0].ti == 16'h0)
        else $error("offset binary zero not mapped to zero");
    width_mask_a: assert property (wm == doss_pkg::DOSS_W14 |-> g_path[0].mi[3:0] == 4'h0
        && g_path[0].mq[3:0] == 4'h0)
        else $error("14-bit mode kept low bits");
    sum_none_a: assert property (ce && sum_sel[3:0] == 4'h0 |=> ch_out[0] == 16'h0)
        else $error("empty sum not zero");
    trim_value_a: assert property (ce && !sys_rst |=> $signed(coarse_trim) ==
        2 * ($signed({1'b0, $past(ctrl[`DOSS_F_TRIM +: 4])}) - 11))
        else $error("coarse trim value wrong");

endmodule // doss_top

// File: tb/doss_link_model.sv
// link transmitter model: held per-path samples, lane alignment and sysref
`timescale 1ns/10ps
module doss_link_model (
    input  wire logic                core_clk,  // sample clock
    input  wire logic                twos,      // send two's complement codes
    input  wire logic                next_set,  // draw a fresh sample set
    input  wire logic                align,     // lane alignment finished
    input  wire logic                ref_pulse, // raise sysref
    output logic [3:0][15:0]         sval,      // signed value of each path
    output doss_pkg::doss_iq_t [3:0] link_iq,   // coded samples per path
    output logic                     ila_done,  // alignment level
    output logic                     sysref_pin // sysref, launched off the clock edge
);
    ////////////////////////////////////////////////////////////
    // the two codings differ only in the msb, so offset binary is built by flipping it
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            link_iq[p].i = {sval[p][15] ^ ~twos, sval[p][14:0]};
            link_iq[p].q = {sval[p][15] ^ ~twos, sval[p][14:0]};
        end
    end
    // samples are held between draws so the inverse sinc filter can settle
    initial begin
        sval = '0;
        ila_done = 1'h0;
        sysref_pin = 1'h0;
    end
    always @(posedge core_clk) begin
        if (next_set) begin
            for (int p = 0; p < 4; p++) sval[p] <= 16'($urandom);
        end
        ila_done <= align;
        sysref_pin <= ref_pulse;
    end
endmodule // doss_link_model

// File: tb/doss_test.sv
// self-checking bench for the output sum and sync block
`timescale 1ns/10ps
`include "doss_consts.svh"
module duc_output_sum_and_sync_test;
    logic              core_clk = 1'h0, sys_rst = 1'h1, ce = 1'h1;
    logic              twos = 1'h0, next_set = 1'h0, align = 1'h0, ref_pulse = 1'h0;
    logic [11:0]       s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]        s_axi_wstrb = 4'hf;
    logic              s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic              s_axi_bready = 1'h1, s_axi_rready = 1'h1, ila_done, sysref_pin;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [1:0][15:0]  ch_out;
    logic signed [5:0] coarse_trim;
    logic [3:0][15:0]  sval;
    logic [15:0]       msk = 16'hffff;
    doss_pkg::doss_iq_t [3:0] link_iq;
    int                err_total = 0, tests_run = 0;

    doss_top DUT (.core_clk, .sys_rst, .ce, .link_iq, .ila_done, .sysref_pin, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ch_out, .coarse_trim);
    doss_link_model LM (.core_clk, .twos, .next_set, .align, .ref_pulse, .sval, .link_iq,
        .ila_done, .sysref_pin);

    // 40 mhz sample clock
    always #12.5 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////
    // comparison, verdict and timeout guard
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic guard(input int n);
        if (n >= 50) begin
            err_total++;
            report_and_stop();
        end
    endtask
    // axi4-lite master; bready and rready stay high so every answer is taken at once
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid && n < 50);
        guard(n);
        check("bresp", 32'(s_axi_bresp), 32'(er));
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid && n < 50);
        guard(n);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    // rounded sum of the selected paths: n inputs keep bits [15+n:n], half lsb added first
    function automatic logic [15:0] exp_sum(input logic [3:0] sel, input int c);
        int s;
        int n;
        s = 0;
        n = 0;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                s += int'($signed(sval[b < 2 ? 2 * c + b : b - 2 * c] & msk));
                n++;
            end
        end
        if (n > 0) s = (s + (1 << (n - 1))) >>> n;
        return 16'(s);
    endfunction
    ////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [7:0]  sel;
        logic [1:0]  wm;
        logic        f;
        d = $urandom(5498);
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'h0;
        @(posedge core_clk);
        rd(`DOSS_A_CTRL, d, r);
        check("ctrl reset", d, `DOSS_R_CTRL);
        rd(12'h018, d, r);
        check("unmapped rresp", 32'(r), 32'(`DOSS_RESP_SLV));
        wr(12'h018, 32'h0000_ffff, `DOSS_RESP_SLV);
        // every trim code, both ends of the range included
        for (int t = 0; t < 16; t++) begin
            wr(`DOSS_A_CTRL, 32'(t) << `DOSS_F_TRIM, `DOSS_RESP_OK);
            repeat (2) @(posedge core_clk);
            check("trim", {26'h0, coarse_trim}, {26'h0, 6'(2 * (t - 11))});
        end
        // all selections, both codings, widths drawn at random; oscillators idle at phase zero
        for (int k = 0; k < 24; k++) begin
            f = k < 16 ? k[0] : 1'($urandom);
            wm = 2'($urandom % 3);
            sel = k < 16 ? {~4'(k), 4'(k)} : 8'($urandom);
            msk = wm == 2'h1 ? 16'hfff0 : wm == 2'h2 ? 16'hfffc : 16'hffff;
            twos <= f;
            next_set <= 1'h1;
            @(posedge core_clk);
            next_set <= 1'h0;
            wr(`DOSS_A_CTRL, 32'h0a10 | 32'(wm) << 1 | 32'(f), `DOSS_RESP_OK);
            wr(`DOSS_A_SUMSEL, 32'(sel), `DOSS_RESP_OK);
            repeat (8) @(posedge core_clk);
            check("sum0", 32'(ch_out[0]), 32'(exp_sum(sel[3:0], 0)));
            check("sum1", 32'(ch_out[1]), 32'(exp_sum(sel[7:4], 1)));
            // with the enable low, fresh link samples must not reach the sum
            if (k == 23) begin
                d = 32'(exp_sum(sel[3:0], 0));
                ce <= 1'h0;
                next_set <= 1'h1;
                repeat (8) @(posedge core_clk);
                check("ce hold", 32'(ch_out[0]), d);
                ce <= 1'h1;
                next_set <= 1'h0;
            end
        end
        // constant 8000: zero in offset binary, negative full scale in two's complement
        wr(`DOSS_A_CONST, 32'h8000, `DOSS_RESP_OK);
        wr(`DOSS_A_SUMSEL, 32'h11, `DOSS_RESP_OK);
        for (int m = 0; m < 2; m++) begin
            wr(`DOSS_A_CTRL, 32'h0a18 | 32'(m), `DOSS_RESP_OK);
            repeat (8) @(posedge core_clk);
            check("fullscale", 32'(ch_out[0]), m ? 32'h0000_c000 : 32'h0);
        end
        // spin path 0 five quarter turns, so every source starts from quadrant 1 (-q)
        wr(`DOSS_A_CONST, 32'h5a7e, `DOSS_RESP_OK);
        for (int k = 0; k < 4; k++) begin
            wr(`DOSS_A_CTRL, 32'h0a19, `DOSS_RESP_OK);
            wr(`DOSS_A_SYNCSEL, 32'h0, `DOSS_RESP_OK);
            wr(`DOSS_A_FREQ + 12'h4, 32'h4000, `DOSS_RESP_OK);
            repeat (2) @(posedge core_clk);
            wr(`DOSS_A_FREQ + 12'h4, 32'h0, `DOSS_RESP_OK);
            wr(`DOSS_A_SYNCSEL, 32'h11 << k, `DOSS_RESP_OK);
            if (k == 0) wr(`DOSS_A_FREQ + 12'h4, 32'h0, `DOSS_RESP_OK);
            if (k == 1) wr(`DOSS_A_CTRL, 32'h1a19, `DOSS_RESP_OK);
            ref_pulse <= k == 2;
            align <= k == 3;
            repeat (10) @(posedge core_clk);
            ref_pulse <= 1'h0;
            check("sync", 32'(ch_out[0]), 32'((16'sh5a7e + 1) >>> 1));
        end
        report_and_stop();
    end
endmodule // duc_output_sum_and_sync_test
